// >>> verilog/wtp_watchdog.sv
// Function
// - Counts oscillator ticks, also during sleep
// - Timeout while running resets the device
// - Timeout while asleep wakes the device
// - Fuse at zero disables watchdog until next reset
// - Base timeout is one full counter pass
// - Software prescaler up to one in 128
// - Clear or sleep zero counter, and prescaler when assigned to watchdog
// - Timeout clears the timeout flag
// - Clear instruction sets both status flags
// - Wake-up keeps control and interrupt mask register contents unchanged
//
// Design decisions made here: the address map and the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
module wtp_watchdog
   import wtp_pkg::*;
(
   // Clock and reset
   input  wire logic        CORE_CLK,
   input  wire logic        RESET,
   // Avalon-MM slave
   input  wire logic [4:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   output logic      [31:0] AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   // Oscillator and fuse pins
   input  wire logic        RC_OSC_IN,
   input  wire logic        WATCHDOG_ENABLE_FUSE,
   // Core side
   input  wire logic        WATCHDOG_CLEAR_INSTRUCTION,
   input  wire logic        SLEEP_INSTRUCTION,
   output logic             DEVICE_RESET,
   output logic             WAKEUP,
   output logic             MAIN_CLOCK_RUN,
   output logic             TIMEOUT_STATUS_FLAG_N,
   output logic             POWERDOWN_STATUS_FLAG_N,
   // Interrupt
   output logic             IRQ
);

   logic                rc_q1_reg, rc_q2_reg, rc_q3_reg;
   logic                fuse_q1_reg, fuse_q2_reg;
   logic                armed_reg, fuse_en_reg;
   logic                rc_edge, tick_en, to_evt, clr_evt, wd_run;
   logic [CNT_W-1:0]    cnt_reg;
   logic [PRE_W-1:0]    pre_reg;
   wtp_ctrl_type        ctrl_reg;
   wtp_flags_type       flags;
   logic                timeout_n_reg, powerdown_n_reg;
   wtp_state_type       state_reg;
   logic                dev_reset_reg, wakeup_reg;
   logic                ack_reg;
   logic [31:0]         rdata_reg, rdata_next;
   logic                wr_en;
   logic [IRQ_W-1:0]    irq_stat_reg, irq_mask_reg, irq_set;

   function automatic logic [PRE_W-1:0] ratio_mask(input logic [RATIO_W-1:0] r);
      ratio_mask = PRE_W'((1 << r) - 1);
   endfunction : ratio_mask

   // Oscillator pin into core domain, kept running through reset so no false edge follows it
   always_ff @(posedge CORE_CLK) begin
      rc_q1_reg <= RC_OSC_IN;
      rc_q2_reg <= rc_q1_reg;
      rc_q3_reg <= rc_q2_reg;
   end

   assign rc_edge = rc_q2_reg & ~rc_q3_reg;

   // Fuse captured once after reset release
   // Synchroniser runs during reset, so the pin level is valid at release
   always_ff @(posedge CORE_CLK) begin
      fuse_q1_reg <= WATCHDOG_ENABLE_FUSE;
      fuse_q2_reg <= fuse_q1_reg;
   end

   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         armed_reg   <= 1'b0;
         fuse_en_reg <= 1'b0;
      end else begin
         armed_reg   <= 1'b1;
         if (!armed_reg && fuse_q1_reg == fuse_q2_reg) begin
            fuse_en_reg <= fuse_q2_reg;
         end
      end
   end

   assign wd_run  = armed_reg & fuse_en_reg;
   assign clr_evt = WATCHDOG_CLEAR_INSTRUCTION
                  | (SLEEP_INSTRUCTION & (state_reg == RUN_ST));

   always_comb begin
      if (ctrl_reg.to_wdt) begin
         tick_en = rc_edge & ((pre_reg & ratio_mask(ctrl_reg.ratio))
                              == ratio_mask(ctrl_reg.ratio));
      end else begin
         tick_en = rc_edge;
      end
   end

   assign to_evt = wd_run & tick_en & ~clr_evt & (cnt_reg == CNT_LAST);

   // Prescaler and counter
   always_ff @(posedge CORE_CLK) begin
      if (RESET || dev_reset_reg) begin
         pre_reg <= '0;
      end else if (clr_evt && ctrl_reg.to_wdt) begin
         pre_reg <= '0;
      end else if (wd_run && ctrl_reg.to_wdt && rc_edge) begin
         pre_reg <= pre_reg + PRE_W'(1);
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RESET || dev_reset_reg) begin
         cnt_reg <= '0;
      end else if (clr_evt) begin
         cnt_reg <= '0;
      end else if (wd_run && tick_en) begin
         cnt_reg <= cnt_reg + CNT_W'(1);
      end
   end

   // Run and sleep
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         state_reg <= RUN_ST;
      end else begin
         unique case (state_reg)
            RUN_ST: begin
               if (SLEEP_INSTRUCTION && !to_evt) begin
                  state_reg <= SLEEP_ST;
               end
            end
            SLEEP_ST: begin
               if (to_evt) begin
                  state_reg <= RUN_ST;
               end
            end
         endcase
      end
   end

   // Reset and wake pulses
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         dev_reset_reg <= 1'b0;
         wakeup_reg    <= 1'b0;
      end else begin
         dev_reset_reg <= to_evt & (state_reg == RUN_ST);
         wakeup_reg    <= to_evt & (state_reg == SLEEP_ST);
      end
   end

   // Status flags, both high after power-on
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         timeout_n_reg   <= 1'b1;
         powerdown_n_reg <= 1'b1;
      end else if (to_evt) begin
         timeout_n_reg <= 1'b0;
         if (state_reg == RUN_ST) begin
            powerdown_n_reg <= 1'b1;
         end
      end else if (WATCHDOG_CLEAR_INSTRUCTION) begin
         timeout_n_reg   <= 1'b1;
         powerdown_n_reg <= 1'b1;
      end else if (SLEEP_INSTRUCTION && state_reg == RUN_ST) begin
         timeout_n_reg   <= 1'b1;
         powerdown_n_reg <= 1'b0;
      end
   end

   // Option register: reloaded by a watchdog reset, kept on wake-up
   always_ff @(posedge CORE_CLK) begin
      if (RESET || dev_reset_reg) begin
         ctrl_reg <= wtp_ctrl_type'(CTRL_RESET);
      end else if (wr_en && AVS_ADDRESS == OFS_CTRL) begin
         ctrl_reg <= wtp_ctrl_type'(AVS_WRITEDATA[3:0]);
      end
   end

   // Bus slave: one wait cycle per access
   assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_reg;
   assign wr_en           = AVS_WRITE & ack_reg & AVS_BYTEENABLE[0];

   assign flags = '{fuse_on:     fuse_en_reg,
                    sleeping:    state_reg == SLEEP_ST,
                    powerdown_n: powerdown_n_reg,
                    timeout_n:   timeout_n_reg};

   always_comb begin
      rdata_next = '0;
      unique case (AVS_ADDRESS)
         OFS_CTRL:     rdata_next[3:0]        = ctrl_reg;
         OFS_STATUS:   rdata_next[3:0]        = flags;
         OFS_COUNT:    rdata_next[15:0]       = {pre_reg, cnt_reg};
         OFS_IRQ_STAT: rdata_next[IRQ_W-1:0]  = irq_stat_reg;
         OFS_IRQ_MASK: rdata_next[IRQ_W-1:0]  = irq_mask_reg;
         default:      rdata_next             = '0;
      endcase
   end

   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         ack_reg   <= 1'b0;
         rdata_reg <= '0;
      end else begin
         ack_reg <= (AVS_READ | AVS_WRITE) & ~ack_reg;
         if (AVS_READ && !ack_reg) begin
            rdata_reg <= rdata_next;
         end
      end
   end

   // Interrupt status, set wins over write-one-clear
   assign irq_set = {wakeup_reg, dev_reset_reg};

   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         irq_stat_reg <= '0;
         irq_mask_reg <= '0;
      end else begin
         if (wr_en && AVS_ADDRESS == OFS_IRQ_STAT) begin
            irq_stat_reg <= (irq_stat_reg & ~AVS_WRITEDATA[IRQ_W-1:0]) | irq_set;
         end else begin
            irq_stat_reg <= irq_stat_reg | irq_set;
         end
         if (wr_en && AVS_ADDRESS == OFS_IRQ_MASK) begin
            irq_mask_reg <= AVS_WRITEDATA[IRQ_W-1:0];
         end
      end
   end

   assign AVS_READDATA            = rdata_reg;
   assign IRQ                     = |(irq_stat_reg & irq_mask_reg);
   assign DEVICE_RESET            = dev_reset_reg;
   assign WAKEUP                  = wakeup_reg;
   assign MAIN_CLOCK_RUN          = state_reg == RUN_ST;
   assign TIMEOUT_STATUS_FLAG_N   = timeout_n_reg;
   assign POWERDOWN_STATUS_FLAG_N = powerdown_n_reg;

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RESET);

   sleep_count_a: assert property (
      state_reg == SLEEP_ST && wd_run && tick_en && !clr_evt && cnt_reg != CNT_LAST
      |=> cnt_reg == $past(cnt_reg) + CNT_W'(1))
      else $error("counter stalled in sleep");

   run_reset_a: assert property (
      to_evt && state_reg == RUN_ST |=> DEVICE_RESET && !WAKEUP ##1 !DEVICE_RESET)
      else $error("no reset pulse on timeout");

   sleep_wake_a: assert property (
      to_evt && state_reg == SLEEP_ST |=> WAKEUP && MAIN_CLOCK_RUN && !DEVICE_RESET)
      else $error("no wake-up on timeout in sleep");

   fuse_off_a: assert property (
      armed_reg && !fuse_en_reg |=> !DEVICE_RESET && !WAKEUP && cnt_reg == $past(cnt_reg)
                                    || $past(clr_evt))
      else $error("disabled watchdog acted");

   full_pass_a: assert property (
      to_evt |-> cnt_reg == CNT_LAST && tick_en)
      else $error("timeout before full pass");

   ratio_max_a: assert property (
      ctrl_reg.to_wdt && ctrl_reg.ratio == 3'h7 && rc_edge && pre_reg[6:0] != 7'h7f
      |-> !tick_en)
      else $error("prescaler ratio wrong");

   clear_zero_a: assert property (
      clr_evt && !dev_reset_reg |=> cnt_reg == '0 && (!ctrl_reg.to_wdt || pre_reg == '0))
      else $error("clear left counter running");

   to_flag_a: assert property (
      to_evt |=> !TIMEOUT_STATUS_FLAG_N)
      else $error("timeout flag not cleared");

   clr_flags_a: assert property (
      WATCHDOG_CLEAR_INSTRUCTION |=> TIMEOUT_STATUS_FLAG_N && POWERDOWN_STATUS_FLAG_N)
      else $error("clear did not set flags");

   wake_keep_a: assert property (
      to_evt && state_reg == SLEEP_ST |=> ctrl_reg == $past(ctrl_reg) ##1
      ctrl_reg == $past(ctrl_reg, 2) || $past(wr_en))
      else $error("wake-up altered registers");

   base_tick_a: assert property (
      !ctrl_reg.to_wdt |-> tick_en == rc_edge)
      else $error("prescaler affected base period");

   osc_sync_a: assert property (
      rc_edge |-> $past(RC_OSC_IN, 2) && !$past(RC_OSC_IN, 3))
      else $error("oscillator edge not synchronised");

endmodule : wtp_watchdog
`default_nettype wire

// >>> verilog/wtp_pkg.sv
`default_nettype none
package wtp_pkg;

   // Counter geometry
   localparam int CNT_W   = 8;
   localparam int PRE_W   = 8;
   localparam int RATIO_W = 3;
   localparam int IRQ_W   = 2;

   // Nominal base timeout, reached by one full pass of the counter
   localparam int BASE_PERIOD_US = 18000;
   localparam int RC_TICK_NS     = (BASE_PERIOD_US * 1000) / (2 ** CNT_W);
   localparam int CORE_PERIOD_NS = 40;
   // Core cycles per oscillator tick, rounded down
   localparam int RC_TICK_CYCLES = RC_TICK_NS / CORE_PERIOD_NS;

   // Register byte offsets
   localparam logic [4:0] OFS_CTRL     = 5'h00;
   localparam logic [4:0] OFS_STATUS   = 5'h04;
   localparam logic [4:0] OFS_COUNT    = 5'h08;
   localparam logic [4:0] OFS_IRQ_STAT = 5'h0c;
   localparam logic [4:0] OFS_IRQ_MASK = 5'h10;

   // Field positions
   localparam int CTRL_RATIO_LSB = 0;
   localparam int CTRL_ASSIGN    = 3;
   localparam int COUNT_PRE_LSB  = 8;
   localparam int IRQ_RESET_BIT  = 0;
   localparam int IRQ_WAKE_BIT   = 1;

   // Control reset value and last counter value
   localparam logic [3:0]       CTRL_RESET = 4'hf;
   localparam logic [CNT_W-1:0] CNT_LAST   = 8'hff;

   typedef struct packed {
      logic               to_wdt;
      logic [RATIO_W-1:0] ratio;
   } wtp_ctrl_type;

   typedef struct packed {
      logic fuse_on;
      logic sleeping;
      logic powerdown_n;
      logic timeout_n;
   } wtp_flags_type;

   typedef enum {RUN_ST, SLEEP_ST} wtp_state_type;

endpackage : wtp_pkg
`default_nettype wire

// >>> dv/wtp_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module wtp_core_model
(
   // Core clock
   input  wire logic clk,
   // Oscillator and instruction pulses
   output logic      rc_osc,
   output logic      clear_pulse,
   output logic      sleep_pulse
);
   logic osc_q   = 1'b0;
   logic clr_q   = 1'b0;
   logic slp_q   = 1'b0;
   int   osc_cnt = 0;

   assign rc_osc      = osc_q;
   assign clear_pulse = clr_q;
   assign sleep_pulse = slp_q;

   // Free running, half period of three core cycles
   always @(posedge clk) begin
      osc_cnt <= (osc_cnt == 2) ? 0 : osc_cnt + 1;
      if (osc_cnt == 2) osc_q <= ~osc_q;
   end

   task automatic pulse(input logic is_sleep);
      @(posedge clk);
      if (is_sleep) slp_q <= 1'b1;
      else clr_q <= 1'b1;
      @(posedge clk);
      slp_q <= 1'b0;
      clr_q <= 1'b0;
   endtask : pulse
endmodule : wtp_core_model
`default_nettype wire

// >>> dv/wtp_watchdog_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module wtp_watchdog_tb_top;
   import wtp_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        fuse = 1'b1;
   logic [4:0]  addr = 5'h00;
   logic        rd_s = 1'b0;
   logic        wr_s = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  be = 4'hf;
   logic [31:0] rdata;
   logic        waitreq, osc, clr, slp, dev_rst, wake, run, to_n, pd_n, irq;
   int          mismatches = 0;
   int          checks_done = 0;
   int          n_rst = 0;
   int          n_wake = 0;
   int          c;

   always #20 clk = ~clk;

   wtp_core_model u_core (.clk(clk), .rc_osc(osc), .clear_pulse(clr), .sleep_pulse(slp));

   wtp_watchdog u_dut (
      .CORE_CLK(clk), .RESET(rst), .AVS_ADDRESS(addr), .AVS_READ(rd_s), .AVS_WRITE(wr_s),
      .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
      .AVS_WAITREQUEST(waitreq), .RC_OSC_IN(osc), .WATCHDOG_ENABLE_FUSE(fuse),
      .WATCHDOG_CLEAR_INSTRUCTION(clr), .SLEEP_INSTRUCTION(slp), .DEVICE_RESET(dev_rst),
      .WAKEUP(wake), .MAIN_CLOCK_RUN(run), .TIMEOUT_STATUS_FLAG_N(to_n),
      .POWERDOWN_STATUS_FLAG_N(pd_n), .IRQ(irq));

   always @(negedge clk) begin
      if (dev_rst === 1'b1) n_rst++;
      if (wake === 1'b1) n_wake++;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
      end
   endtask : chk

   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      @(posedge clk);
      addr  <= a;
      rd_s  <= ~w;
      wr_s  <= w;
      wdata <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (waitreq !== 1'b0 && n < 20);
      chk({31'h0, waitreq}, 32'h0);
      q = rdata;
      rd_s <= 1'b0;
      wr_s <= 1'b0;
   endtask : bus

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
      @(negedge clk);
   endtask : wr

   task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, exp);
   endtask : rdc

   // Cycles from now until a reset or wake pulse, compared with a tick count
   task automatic wait_evt(input int ticks);
      int base;
      base = n_rst + n_wake;
      c = 0;
      while (n_rst + n_wake == base && c < 8000) begin
         @(negedge clk);
         c++;
      end
      chk(32'(c >= ticks * 6 - 6 && c <= ticks * 6 + 12), 32'h1);
   endtask : wait_evt

   task automatic rst_dut(input logic f);
      @(posedge clk);
      fuse <= f;
      rst  <= 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
   endtask : rst_dut

   task automatic end_sim();
      if (mismatches == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim

   initial begin
      repeat (60000) @(posedge clk);
      mismatches++;
      end_sim();
   end

   initial begin
      rst_dut(1'b1);
      rdc(OFS_CTRL, 32'hf);
      be <= 4'he;
      wr(OFS_CTRL, 32'h0);
      be <= 4'hf;
      rdc(OFS_CTRL, 32'hf);
      rdc(OFS_STATUS, 32'hb);
      rdc(5'h14, 32'h0);
      wr(OFS_STATUS, 32'h0);
      rdc(OFS_STATUS, 32'hb);
      wr(OFS_CTRL, 32'h7);
      wr(OFS_IRQ_MASK, 32'h1);
      u_core.pulse(1'b0);
      wait_evt(256);
      chk(n_rst, 1);
      chk(to_n, 1'b0);
      @(negedge clk);
      chk(irq, 1'b1);
      rdc(OFS_IRQ_STAT, 32'h1);
      rdc(OFS_CTRL, 32'hf);
      wr(OFS_IRQ_STAT, 32'h1);
      chk(irq, 1'b0);
      u_core.pulse(1'b0);
      @(negedge clk);
      chk({to_n, pd_n}, 2'b11);
      rdc(OFS_COUNT, 32'h0);
      wr(OFS_CTRL, 32'h9);
      u_core.pulse(1'b0);
      wait_evt(512);
      wr(OFS_CTRL, 32'h0);
      for (int i = 0; i < 3; i++) begin
         repeat (1000) @(posedge clk);
         u_core.pulse(1'b0);
      end
      chk(n_rst, 2);
      wr(OFS_IRQ_MASK, 32'h2);
      u_core.pulse(1'b1);
      @(negedge clk);
      chk({run, to_n, pd_n}, 3'b010);
      rdc(OFS_STATUS, 32'hd);
      wait_evt(256);
      chk(n_rst, 2);
      chk(n_wake, 1);
      @(negedge clk);
      chk({run, to_n, pd_n, irq}, 4'b1001);
      rdc(OFS_CTRL, 32'h0);
      wr(OFS_IRQ_MASK, 32'h0);
      chk(irq, 1'b0);
      wr(OFS_IRQ_STAT, 32'h2);
      wr(OFS_IRQ_MASK, 32'h2);
      chk(irq, 1'b0);
      rst_dut(1'b0);
      wr(OFS_CTRL, 32'h0);
      repeat (2500) @(posedge clk);
      chk(n_rst + n_wake, 3);
      rdc(OFS_STATUS, 32'h3);
      end_sim();
   end
endmodule : wtp_watchdog_tb_top
`default_nettype wire
